// ==== shared/adcpm_pkg.sv ====
// Purpose: Shared constants and types for the converter power/clock control
// Assumes: 10 MHz system clock, AXI4-Lite register access
// Notes: Divider and wake counts derive from the times and rates named here
package adcpm_pkg;
    // System clock rate
    localparam int CLK_HZ = 10_000_000;
    // Internal conversion clock, shutdown pin floating
    localparam int FAST_HZ = 1_800_000;
    // Internal conversion clock, shutdown pin driven high
    localparam int SLOW_HZ = 225_000;
    // Divider periods, rounded down so the rate is never slower
    localparam logic [7:0] FAST_DIV = 8'(CLK_HZ / FAST_HZ);
    localparam logic [7:0] SLOW_DIV = 8'(CLK_HZ / SLOW_HZ);
    // Wake time after the shutdown pin is driven high
    localparam int WAKE_NS = 2000;
    localparam logic [7:0] WAKE_CYC = 8'((WAKE_NS * (CLK_HZ / 1000)) / 1000000);
    // Result layout: 10 code bits, 12-bit field, 16 bits shifted in all
    localparam int RES_BITS = 10;
    localparam int OUT_BITS = 16;
    localparam logic [4:0] OUT_CNT = 5'(OUT_BITS);
    localparam logic [3:0] RES_CNT = 4'(RES_BITS);
    localparam logic [3:0] CTRL_CNT = 4'h8;
    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_STATUS = 4'h4;
    localparam logic [3:0] OFS_RESULT = 4'h8;
    localparam logic CTRL_RESET = 1'b1;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Power-select field values
    localparam logic [1:0] SEL_DEEP = 2'h0;
    localparam logic [1:0] SEL_LIGHT = 2'h1;
    localparam logic [1:0] SEL_INT = 2'h2;
    localparam logic [1:0] SEL_EXT = 2'h3;
    // Transfer and conversion sequence
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_CTRL = 3'h1,
        ST_ARM = 3'h2,
        ST_EXT_STRB = 3'h3,
        ST_EXT_CONV = 3'h4,
        ST_INT_CONV = 3'h5
    } adcpm_state_type;
    // Power state
    typedef enum logic [1:0] {
        PWR_ON = 2'h0,
        PWR_LIGHT = 2'h1,
        PWR_DEEP = 2'h2,
        PWR_HW = 2'h3
    } adcpm_pwr_type;
endpackage

// ==== rtl/adcpm_pin_sync.sv ====
// Purpose: Three-stage synchroniser with agreement filter and edge pulses
// Assumes: Inputs are asynchronous to clock_in
// Notes: A change counts once stages two and three agree
module adcpm_pin_sync #(
    parameter int W = 1
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level_out,
    output logic [W-1:0] rise_out,
    output logic [W-1:0] fall_out
);
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            logic s1_q, s2_q, s3_q; // Stage one is read by stage two only
            // Chain plus filtered level and edge flags
            always_ff @(posedge clock_in or negedge arst_n_in) begin
                if (!arst_n_in) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    level_out[i] <= 1'b0;
                    rise_out[i] <= 1'b0;
                    fall_out[i] <= 1'b0;
                end else begin
                    s1_q <= pin_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    rise_out[i] <= (s2_q == s3_q) && s3_q && !level_out[i];
                    fall_out[i] <= (s2_q == s3_q) && !s3_q && level_out[i];
                    if (s2_q == s3_q) begin
                        level_out[i] <= s3_q;
                    end
                end
            end
        end
    endgenerate
endmodule

// ==== rtl/adcpm_ctrl.sv ====
// Purpose: Power-down and clock-mode control of a 10-bit serial converter
// Assumes: Serial pins and shutdown pin are asynchronous to clock_in
// Notes: Analog path gives its code on sample_code_in; this block sequences
// Behaviour
// - Floating shutdown pin gives 1.8MHz internal clock; the divider of 5 here gives 2MHz
// - Shutdown pin high gives 225kHz internal clock; the divider of 44 here gives 227kHz
// - Two low control bits select power and clock
// - Software power-down finishes current conversion first
// - Internal mode result readable after power-down
// - First one bit starts and wakes device
// - Upper bit keeps power; 00 sleeps after conversion
// - Shutdown pin low aborts conversion at once
// - Operational within 2us after pin driven high
// - Result is straight binary, 1024 steps
// - Strobe falling edge marks conversion under way
// - Sixteen bits: 12-bit field then four discarded
// - Select codes: deep, light, internal, external
// - Shutdown pin low overrides the select bits
// - Conversion starts on fall after eighth bit
//
// Design decisions made here: the register offsets and the AXI4-Lite slave port.
module adcpm_ctrl
    import adcpm_pkg::*;
#(
    parameter logic [3:0] INT_CONV_TICKS = 4'hc
) (
    input wire logic clock_in,
    input wire logic arst_n_in,
    // AXI4-Lite slave
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [3:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Serial link and pins
    input wire logic cs_n_in,
    input wire logic sclk_in,
    input wire logic din_in,
    input wire logic hw_sleep_pin_n_in,
    input wire logic hw_sleep_float_in,
    input wire logic [RES_BITS-1:0] sample_code_in,
    output logic dout_out,
    output logic dout_oe_n_out,
    output logic conversion_strobe_out,
    output logic conversion_strobe_oe_n_out,
    output logic bias_on_out,
    output logic ref_on_out
);
    logic [4:0] lvl, rise, fall; // Synchronised pins and edges
    logic cs_n, sclk_r, sclk_f, din, pin_hi, pin_flt;
    logic hw_sleep; // Pin actively low
    logic link_ok; // Receive path usable
    logic int_tick; // Internal conversion clock enable
    adcpm_state_type state_q;
    adcpm_pwr_type pwr_q;
    logic [7:0] shift_q; // Control byte being received
    logic [3:0] cnt_q; // Bit and tick counter
    logic [1:0] sel_q; // Power-select bits of the last byte
    logic ext_mode_q; // Last specified clock mode
    logic [RES_BITS-1:0] sample_q, result_q;
    logic result_valid_q;
    logic [OUT_BITS-1:0] out_sh_q;
    logic [4:0] out_cnt_q;
    logic out_pend_q, out_act_q;
    logic [7:0] div_q, wake_q;
    logic awake_q;
    logic conv_done; // One-cycle completion
    logic link_en_q; // Software enable of the serial receiver

    // Pin synchroniser, one lane per pin
    adcpm_pin_sync #(.W(5)) u_sync (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .pin_in({hw_sleep_float_in, hw_sleep_pin_n_in, din_in, sclk_in,
                 cs_n_in}),
        .level_out(lvl),
        .rise_out(rise),
        .fall_out(fall)
    );
    assign cs_n = lvl[0];
    assign sclk_r = rise[1];
    assign sclk_f = fall[1];
    assign din = lvl[2];
    assign pin_hi = lvl[3];
    assign pin_flt = lvl[4];
    assign hw_sleep = !pin_flt && !pin_hi;
    assign link_ok = !cs_n && link_en_q && awake_q && !hw_sleep;

    // Internal conversion clock divider
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            div_q <= 8'h0;
        end else if (int_tick || hw_sleep) begin
            div_q <= 8'h0;
        end else begin
            div_q <= div_q + 8'h1;
        end
    end
    // Floating pin picks the fast rate, driven high the slow one
    assign int_tick = !hw_sleep &&
        (div_q == (pin_flt ? FAST_DIV : SLOW_DIV) - 8'h1);

    // Wake timer after leaving hardware sleep
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wake_q <= 8'h0;
            awake_q <= 1'b0;
        end else if (hw_sleep) begin
            wake_q <= 8'h0;
            awake_q <= 1'b0;
        end else if (!awake_q) begin
            // Counted from the synchronised edge, so it ends early enough
            wake_q <= wake_q + 8'h1;
            awake_q <= (wake_q >= WAKE_CYC - 8'h5);
        end
    end

    assign conv_done = (state_q == ST_EXT_CONV && sclk_f &&
                        cnt_q == RES_CNT - 4'h1) ||
                       (state_q == ST_INT_CONV && int_tick &&
                        cnt_q == INT_CONV_TICKS - 4'h1);

    // Transfer and conversion sequence
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_q <= ST_IDLE;
            shift_q <= 8'h0;
            cnt_q <= 4'h0;
            sel_q <= SEL_INT;
            ext_mode_q <= 1'b0;
            sample_q <= '0;
        end else if (hw_sleep) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    // First one on the data line is the start bit
                    if (link_ok && sclk_r && din) begin
                        state_q <= ST_CTRL;
                        shift_q <= 8'h1;
                        cnt_q <= 4'h1;
                    end
                end
                ST_CTRL: begin
                    if (cs_n) begin
                        state_q <= ST_IDLE;
                    end else if (sclk_r) begin
                        shift_q <= {shift_q[6:0], din};
                        cnt_q <= cnt_q + 4'h1;
                        if (cnt_q == CTRL_CNT - 4'h1) begin
                            state_q <= ST_ARM;
                            sel_q <= {shift_q[0], din};
                        end
                    end
                end
                ST_ARM: begin
                    // Start waits for the fall after the last bit
                    if (cs_n) begin
                        state_q <= ST_IDLE;
                    end else if (sclk_f) begin
                        sample_q <= sample_code_in;
                        cnt_q <= 4'h0;
                        // Power-down codes convert in the old mode
                        if (sel_q[1]) begin
                            ext_mode_q <= sel_q[0];
                        end
                        if (sel_q[1] ? sel_q[0] : ext_mode_q) begin
                            state_q <= ST_EXT_STRB;
                        end else begin
                            state_q <= ST_INT_CONV;
                        end
                    end
                end
                ST_EXT_STRB: begin
                    if (cs_n) begin
                        state_q <= ST_IDLE;
                    end else if (sclk_f) begin
                        state_q <= ST_EXT_CONV;
                        cnt_q <= 4'h1;
                    end
                end
                ST_EXT_CONV: begin
                    // Serial clock drives the decisions; select high aborts
                    if (cs_n) begin
                        state_q <= ST_IDLE;
                    end else if (conv_done) begin
                        state_q <= ST_IDLE;
                    end else if (sclk_f) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                ST_INT_CONV: begin
                    // Select high does not disturb internal conversion
                    if (conv_done) begin
                        state_q <= ST_IDLE;
                    end else if (int_tick) begin
                        cnt_q <= cnt_q + 4'h1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Power state
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pwr_q <= PWR_ON;
        end else if (hw_sleep) begin
            pwr_q <= PWR_HW;
        end else if (pwr_q == PWR_HW) begin
            pwr_q <= PWR_ON;
        end else if (state_q == ST_IDLE && link_ok && sclk_r && din) begin
            pwr_q <= PWR_ON;
        end else if (conv_done) begin
            // Sleep only once the result is in
            if (sel_q[1]) begin
                pwr_q <= PWR_ON;
            end else if (sel_q == SEL_LIGHT) begin
                pwr_q <= PWR_LIGHT;
            end else begin
                pwr_q <= PWR_DEEP;
            end
        end
    end
    assign bias_on_out = (pwr_q == PWR_ON);
    assign ref_on_out = (pwr_q == PWR_ON) || (pwr_q == PWR_LIGHT);

    // Result store and output shifter
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            result_q <= '0;
            result_valid_q <= 1'b0;
            out_sh_q <= '0;
            out_cnt_q <= 5'h0;
            out_pend_q <= 1'b0;
            out_act_q <= 1'b0;
        end else if (hw_sleep) begin
            result_valid_q <= 1'b0;
            out_pend_q <= 1'b0;
            out_act_q <= 1'b0;
        end else begin
            if (conv_done) begin
                result_q <= sample_q;
                result_valid_q <= 1'b1;
            end
            if (state_q == ST_EXT_STRB && sclk_f && !cs_n) begin
                // MSB leaves with the strobe fall
                out_sh_q <= {sample_q, 6'h0};
                out_cnt_q <= OUT_CNT - 5'h1;
                out_act_q <= 1'b1;
            end else if (conv_done && state_q == ST_INT_CONV) begin
                // Kept while asleep; first fall after done shows MSB
                out_sh_q <= {sample_q, 6'h0};
                out_pend_q <= 1'b1;
            end else if (sclk_f && out_pend_q) begin
                out_pend_q <= 1'b0;
                out_act_q <= 1'b1;
                out_cnt_q <= OUT_CNT - 5'h1;
            end else if (sclk_f && out_act_q) begin
                out_sh_q <= {out_sh_q[OUT_BITS-2:0], 1'b0};
                out_cnt_q <= out_cnt_q - 5'h1;
                out_act_q <= (out_cnt_q != 5'h0);
            end
        end
    end
    // Zeros shift out while no result is being presented
    assign dout_out = out_act_q && out_sh_q[OUT_BITS-1];
    assign dout_oe_n_out = cs_n || hw_sleep;
    // Internal mode: low while converting; external: one-period pulse
    assign conversion_strobe_out = (state_q == ST_EXT_STRB) ||
        (!ext_mode_q && state_q != ST_INT_CONV);
    assign conversion_strobe_oe_n_out = hw_sleep || (ext_mode_q && cs_n);

    // AXI4-Lite write channel
    logic aw_have_q, w_have_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
    assign s_axi_wready = !w_have_q && !s_axi_bvalid;
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            link_en_q <= CTRL_RESET;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end
            if (aw_have_q && w_have_q) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (aw_addr_q == OFS_CTRL) begin
                    s_axi_bresp <= RESP_OKAY;
                    if (w_strb_q[0]) begin
                        link_en_q <= w_data_q[0];
                    end
                end else if (aw_addr_q == OFS_STATUS ||
                             aw_addr_q == OFS_RESULT) begin
                    s_axi_bresp <= RESP_OKAY; // Read-only, write ignored
                end else begin
                    s_axi_bresp <= RESP_SLVERR;
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // AXI4-Lite read channel
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == OFS_CTRL) begin
                s_axi_rdata <= {31'h0, link_en_q};
            end else if (s_axi_araddr == OFS_STATUS) begin
                s_axi_rdata <= {23'h0, awake_q, result_valid_q, ext_mode_q,
                                pwr_q, 1'b0, state_q};
            end else if (s_axi_araddr == OFS_RESULT) begin
                s_axi_rdata <= {22'h0, result_q};
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    a_hw_sleep_abort: assert property (hw_sleep |=>
        (state_q == ST_IDLE && !result_valid_q && pwr_q == PWR_HW))
        else $error("hardware sleep did not abort");
    a_fast_div_rate: assert property ((int_tick && pin_flt && !hw_sleep)
        |=> (!int_tick || hw_sleep || !pin_flt) [*4] ##1
            (int_tick || hw_sleep || !pin_flt))
        else $error("fast internal clock period wrong");
    a_slow_div_rate: assert property ((int_tick && !pin_flt)
        |-> ##44 (int_tick || pin_flt || hw_sleep))
        else $error("slow internal clock period wrong");
    a_start_wakes: assert property ((state_q == ST_IDLE && link_ok &&
        sclk_r && din) |=> (pwr_q == PWR_ON && state_q == ST_CTRL))
        else $error("start bit did not wake");
    a_sleep_after: assert property ((conv_done && sel_q == SEL_DEEP)
        |=> pwr_q == PWR_DEEP && result_valid_q)
        else $error("no deep sleep after conversion");
    a_stay_powered: assert property ((conv_done && sel_q[1])
        |=> pwr_q == PWR_ON)
        else $error("upper select bit did not keep power");
    a_conv_on_fall: assert property ((state_q == ST_ARM && !cs_n &&
        sclk_f) |=> (state_q == ST_EXT_STRB || state_q == ST_INT_CONV))
        else $error("conversion did not start on fall");
    a_ext_strobe: assert property ((state_q == ST_EXT_STRB && sclk_f &&
        !cs_n) |-> conversion_strobe_out ##1 !conversion_strobe_out)
        else $error("external strobe edge missing");
    a_wake_time: assert property ($fell(hw_sleep) |-> ##[1:20] awake_q)
        else $error("wake took longer than 2us");
    a_int_readout: assert property (($rose(out_pend_q) &&
        !ext_mode_q) |-> (out_sh_q[OUT_BITS-1 -: RES_BITS] == result_q))
        else $error("stored result not presented");
endmodule

// ==== tb/adcpm_host.sv ====
// Purpose: Serial host model driving the converter link
// Assumes: Link clock of 800 ns built from 4 + 4 system clocks
// Notes: Link clock stays low outside frames; din idles low
module adcpm_host (
    input wire logic clock_in,
    input wire logic dout_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic din_out
);
    timeunit 1ns;
    timeprecision 1ns;
    // Idle: deselected, no start bit offered
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b0;
        din_out = 1'b0;
    end
    // Half link period; slow enough for any mode
    task automatic half(input logic s);
        repeat (4) @(posedge clock_in);
        sclk_out <= s;
    endtask
    // Control byte, start bit first
    task automatic send(input logic [7:0] c);
        @(posedge clock_in);
        cs_n_out <= 1'b0;
        for (int i = 7; i >= 0; i--) begin
            din_out <= c[i];
            half(1'b1);
            half(1'b0);
        end
        din_out <= 1'b0;
    endtask
    // One pulse; its fall brings the first result bit
    task automatic pulse();
        half(1'b1);
        half(1'b0);
    endtask
    // Sixteen bits, each taken late in the high phase, then deselect
    task automatic get16(output logic [15:0] r);
        for (int i = 0; i < 16; i++) begin
            half(1'b1);
            // The block shows each bit five clocks after the fall
            repeat (4) @(posedge clock_in);
            r = {r[14:0], dout_in};
            sclk_out <= 1'b0;
        end
        @(posedge clock_in);
        cs_n_out <= 1'b1;
    endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for converter power and clock control
// Assumes: Host model drives the link; bus readies sampled at falling edge
// Notes: Bus inputs move only at rising edges, so readies hold till then
module tb
    import adcpm_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clock_in, arst_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, dout_out, dout_oe_n_out, conversion_strobe_out;
    logic conversion_strobe_oe_n_out, bias_on_out, ref_on_out;
    logic cs_n_in, sclk_in, din_in, hw_sleep_pin_n_in, hw_sleep_float_in;
    logic [3:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic [RES_BITS-1:0] sample_code_in;
    logic [15:0] r;
    int fail_count = 0, check_count = 0, n, lo;
    // Undriven data line floats
    wire dout_w = dout_oe_n_out ? 1'bz : dout_out;
    always #50 clock_in = ~clock_in;
    adcpm_ctrl u_dut (.clock_in, .arst_n_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .cs_n_in,
        .sclk_in, .din_in, .hw_sleep_pin_n_in, .hw_sleep_float_in,
        .sample_code_in, .dout_out, .dout_oe_n_out, .conversion_strobe_out,
        .conversion_strobe_oe_n_out, .bias_on_out, .ref_on_out);
    adcpm_host u_host (.clock_in, .dout_in(dout_w), .cs_n_out(cs_n_in),
        .sclk_out(sclk_in), .din_out(din_in));
    task automatic chk(input bit ok, input string m);
        check_count++;
        if (!ok) begin
            fail_count++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // A wait ran out: count it and close the run
    task automatic stop(input string m);
        chk(1'b0, m);
        final_report();
    endtask
    // One bus transfer; each valid drops after its own handshake
    task automatic axi(input bit wr, input logic [3:0] a,
                       input logic [31:0] d);
        bit done, aw, w, ar;
        done = 0;
        @(posedge clock_in);
        s_axi_awaddr <= a;
        s_axi_araddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= wr;
        s_axi_wvalid <= wr;
        s_axi_arvalid <= !wr;
        for (int i = 0; i < 50 && !done; i++) begin
            @(negedge clock_in);
            aw = s_axi_awready;
            w = s_axi_wready;
            ar = s_axi_arready;
            done = wr ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
            rd = s_axi_rdata;
            rs = wr ? s_axi_bresp : s_axi_rresp;
            @(posedge clock_in);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            if (ar) s_axi_arvalid <= 1'b0;
        end
        if (!done) stop("bus timeout");
    endtask
    // Bounded wait for a strobe level, counting cycles
    task automatic wst(input logic v, output int k);
        for (k = 0; k < 1000 && conversion_strobe_out !== v; k++)
            @(negedge clock_in);
        if (k == 1000) stop("strobe wait");
    endtask
    task automatic t_regs();
        axi(0, OFS_CTRL, 0);
        chk(rd === {31'h0, CTRL_RESET} && rs === RESP_OKAY, "ctrl reset");
        axi(1, OFS_CTRL, 32'h0);
        axi(0, OFS_CTRL, 0);
        chk(rd === 32'h0, "ctrl readback");
        // Receiver switched off: a full byte must not start anything
        u_host.send(8'h82);
        repeat (8) @(negedge clock_in);
        chk(conversion_strobe_out === 1'b1, "gated receiver");
        axi(1, OFS_CTRL, 32'h1);
        chk(rs === RESP_OKAY, "ctrl write");
        axi(0, 4'hc, 0);
        chk(rs === RESP_SLVERR && rd === 32'h0, "unmapped read");
    endtask
    // Internal-clock conversion: strobe low for a set number of ticks
    task automatic t_int(input logic [7:0] c, input int div,
                         input logic [9:0] code);
        @(posedge clock_in);
        sample_code_in <= code;
        u_host.send(c);
        wst(1'b0, n);
        chk(bias_on_out === 1'b1, "not awake");
        wst(1'b1, lo);
        // From the byte's last fall: five sync clocks, then 12 ticks
        n = n + lo;
        chk(n >= 11 * div + 7 && n <= 12 * div + 6, "ticks");
        u_host.pulse();
        u_host.get16(r);
        chk(r === {code, 6'h00}, "internal result");
    endtask
    task automatic t_ext();
        @(posedge clock_in);
        sample_code_in <= 10'h2a5;
        u_host.send(8'h83);
        repeat (6) @(negedge clock_in);
        chk(conversion_strobe_out === 1'b1, "strobe early");
        u_host.pulse();
        repeat (6) @(negedge clock_in);
        chk(conversion_strobe_out === 1'b0, "strobe fall");
        u_host.get16(r);
        chk(r === {10'h2a5, 6'h00}, "external result");
        axi(0, OFS_RESULT, 0);
        chk(rd[9:0] === 10'h2a5 && bias_on_out === 1'b1, "stay on");
    endtask
    // Pin pulled low mid conversion, then driven high
    task automatic t_hw();
        u_host.send(8'h83);
        u_host.pulse();
        @(posedge clock_in);
        hw_sleep_float_in <= 1'b0;
        hw_sleep_pin_n_in <= 1'b0;
        repeat (8) @(negedge clock_in);
        chk(bias_on_out === 1'b0 && dout_oe_n_out === 1'b1 &&
            conversion_strobe_oe_n_out === 1'b1, "hw sleep");
        axi(0, OFS_STATUS, 0);
        chk(rd[7] === 1'b0, "stale result");
        @(posedge clock_in);
        hw_sleep_pin_n_in <= 1'b1;
        repeat (30) @(posedge clock_in);
        axi(0, OFS_STATUS, 0);
        chk(rd[8] === 1'b1, "wake time");
        t_int(8'h82, SLOW_DIV, 10'h0f0);
    endtask
    initial begin
        clock_in = 1'b0;
        arst_n_in = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        sample_code_in = 10'h000;
        hw_sleep_pin_n_in = 1'b1;
        hw_sleep_float_in = 1'b1;
        repeat (10) @(posedge clock_in);
        arst_n_in <= 1'b1;
        repeat (40) @(posedge clock_in);
        t_regs();
        t_ext();
        t_int(8'h82, FAST_DIV, 10'h155);
        t_int(8'h80, FAST_DIV, 10'h3ff);
        chk(bias_on_out === 1'b0 && ref_on_out === 1'b0, "deep");
        t_int(8'h81, FAST_DIV, 10'h001);
        chk(bias_on_out === 1'b0 && ref_on_out === 1'b1, "light");
        t_hw();
        final_report();
    end
endmodule
